// ==== src/dor_pkg.sv ====
/*
  package for the dsp special register bank: addresses, nvram map,
  operation codes and the packed carriers shared by the bank's ports.
  assumes a 7-bit dsp register address space and a 1k x 8 nvram.
*/
package dor_pkg;

  // dsp register addresses
  localparam logic [6:0] ADDR_RES_FIRST   = 7'h61;
  localparam logic [6:0] ADDR_RES_LAST    = 7'h68;
  localparam logic [6:0] ADDR_PULSE_0     = 7'h6D;
  localparam logic [6:0] ADDR_PULSE_1     = 7'h6E;
  localparam logic [6:0] ADDR_TIMER       = 7'h6F;
  localparam logic [6:0] ADDR_MEM_CTRL    = 7'h70;
  localparam logic [6:0] ADDR_MEM_ADD     = 7'h71;
  localparam logic [6:0] ADDR_MEM_DATA    = 7'h72;
  localparam logic [6:0] ADDR_MEM_U8      = 7'h73;
  localparam logic [6:0] ADDR_MEM_S8      = 7'h74;
  localparam logic [6:0] ADDR_MEM_U16     = 7'h75;
  localparam logic [6:0] ADDR_MEM_S16     = 7'h76;
  localparam logic [6:0] ADDR_MEM_U24     = 7'h77;
  localparam logic [6:0] ADDR_MEM_LAST    = 7'h78;
  localparam logic [6:0] ADDR_TDC_START   = 7'h79;
  localparam logic [6:0] ADDR_TDC_STOP    = 7'h7A;
  localparam logic [6:0] ADDR_CAP_PTR     = 7'h7B;
  localparam logic [6:0] ADDR_RES_PTR     = 7'h7C;

  // operation select bits in the nvram control register
  localparam int MEM_STORE_BIT   = 0;
  localparam int MEM_RECALL_BIT  = 1;
  localparam int MEM_WE_BIT      = 2;
  localparam int MEM_PROTECT_BIT = 3;

  // nvram map
  localparam int             NV_DEPTH        = 1024;
  localparam logic [9:0]     NV_SEC0_LAST    = 10'h2BF;
  localparam logic [9:0]     NV_SEC1_LAST    = 10'h33F;
  localparam logic [9:0]     NV_SEC2_LAST    = 10'h3BF;
  localparam logic [9:0]     NV_CFG_LAST     = 10'h3EF;
  localparam logic [9:0]     NV_LOCK_ADDR    = 10'h3F0;
  localparam logic [9:0]     NV_TRIM_FIRST   = 10'h3FE;
  localparam logic [9:0]     NV_LAST         = 10'h3FF;
  localparam logic [1:0]     LOCK_CFG_BIT    = 2'h3;

  // boot control byte inside the configuration area
  localparam logic [9:0]     NV_BOOT_ADDR    = 10'h3C0;
  localparam int             BOOT_AUTO_BIT   = 0;
  localparam int             BOOT_RUN_BIT    = 1;

  typedef enum logic [3:0] {
    CP_IDLE   = 4'h1,
    CP_STORE  = 4'h2,
    CP_RECALL = 4'h4,
    CP_BOOT   = 4'h8
  } dor_copy_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } dor_dsp_req_t;

  typedef struct packed {
    logic [31:0] tdc_start;
    logic [31:0] tdc_stop;
    logic [31:0] cap_result_pointer;
    logic [31:0] res_result_pointer;
  } dor_tdc_info_t;

endpackage : dor_pkg

// ==== src/dor_regs.sv ====
/*
  dsp special register bank: result words for the host, pulse output
  levels, oscillator-timed delay timer, nvram sram/flash with section
  locks, store/recall copy engine and power-on boot mode selection.
  assumes the dsp request, the host selector and the copy requests come
  from logic on core_clk; only the oscillator clock arrives from outside.
*/
// Notes on behaviour
// R1 - eight 32-bit result words at 97..104, dsp writes, host reads them
// R2 - dsp reads of the result words never return the stored value
// R3 - words at 109 and 110 hold the two pulse output levels
// R4 - 16-bit delay timer counts oscillator cycles, works while dsp halted
// R5 - write to 111 restarts count at zero; at written value, wake trigger
// R6 - firmware must enable timer wake source bit 3 before halting
// R7 - expired flag keeps updating while dsp runs, so it can be polled
// R8 - expired flag is active low, read as jump flag 50
// R9 - addresses 112..120 move one to four bytes, signed or unsigned
// R10 - operation select offers store, recall, write enable and protect
// R11 - address register picks the byte; write data at 114, reads 114..120
// R12 - after nvram writes firmware pulses output flags 7 and 6 to reload
// R13 - program memory is 1k nvram plus 3k rom
// R14 - user sections 0..703, 704..831, 832..959 guarded by lock bits 0..2
// R15 - per-section protection; config and trim share lock bit 3; lock at 1008
// R16 - nvram is sram plus flash; store copies all, recall copies back
// R17 - autoboot with stored contents starts measuring right after power-on
// R18 - stored contents without run flag or autoboot: configured but idle
// R19 - in pure slave use the host reloads the sram after each power-on
// R20 - addresses 121..124 expose time conversion and pointer data to read
// R21 - host writes the activation code before each store, recall, erase
// R22 - timer is one-shot: one trigger, then stops until written again
// R23 - result and level words update in one cycle, never partly seen
`timescale 1ns/1ps
`default_nettype none

module dor_regs (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // dsp register port
  input  wire dor_pkg::dor_dsp_req_t  dsp_req,
  output logic [31:0]                 dsp_rdata,
  output logic                        delay_expired_flag_n,
  output logic                        wake_trigger,
  // time conversion data from the front end
  input  wire dor_pkg::dor_tdc_info_t tdc_info,
  // host result read
  input  wire logic [2:0]             host_res_sel,
  output logic [31:0]                 host_res_data,
  // pulse output generators
  output logic [15:0]                 pulse_out_level_0,
  output logic [15:0]                 pulse_out_level_1,
  // oscillator clock pin
  input  wire logic                   low_freq_osc_clock,
  // flash control from the serial side
  input  wire logic                   flash_store_req,
  input  wire logic                   flash_recall_req,
  input  wire logic                   flash_has_content,
  output logic                        flash_busy,
  // boot outcome
  output logic                        measure_start,
  output logic                        run_flag,
  output logic                        device_idle
);

  // returns the lock bit guarding an nvram byte, bit 2 high when unguarded
  function automatic logic [2:0] lock_index(input logic [9:0] a);
    if (a <= dor_pkg::NV_SEC0_LAST)                      return 3'h0; // R14
    else if (a <= dor_pkg::NV_SEC1_LAST)                 return 3'h1; // R14
    else if (a <= dor_pkg::NV_SEC2_LAST)                 return 3'h2; // R14
    else if (a <= dor_pkg::NV_CFG_LAST)                  return 3'h3; // R15
    else if (a >= dor_pkg::NV_TRIM_FIRST)                return 3'h3; // R15
    else                                                 return 3'h4;
  endfunction : lock_index

  // sign or zero extension of the low n bytes of the assembled read
  function automatic logic [31:0] extend(input logic [31:0] v,
                                         input logic [1:0]  nbytes,
                                         input logic        sgn);
    logic [31:0] r;
    r = v;
    unique case (nbytes)
      2'h1:    r = {{24{sgn & v[7]}},  v[7:0]};
      2'h2:    r = {{16{sgn & v[15]}}, v[15:0]};
      2'h3:    r = {{8{sgn & v[23]}},  v[23:0]};
      2'h0:    r = v;
    endcase
    return r;
  endfunction : extend

  // storage
  logic [31:0] result_word_r [0:7];
  logic [7:0]  sram_r        [0:dor_pkg::NV_DEPTH-1]; // R13
  logic [7:0]  flash_r       [0:dor_pkg::NV_DEPTH-1]; // R16

  logic        dsp_wr_hit;
  logic [2:0]  res_idx;
  logic [15:0] pulse_out_level_0_r;
  logic [15:0] pulse_out_level_1_r;

  assign dsp_wr_hit = dsp_req.wr;
  assign res_idx    = 3'(dsp_req.addr - dor_pkg::ADDR_RES_FIRST);

  // whole word stored on one edge, so the host never sees a mix
  always_ff @(posedge core_clk) begin
    if (dsp_wr_hit && dsp_req.addr >= dor_pkg::ADDR_RES_FIRST &&
        dsp_req.addr <= dor_pkg::ADDR_RES_LAST) begin
      result_word_r[res_idx] <= dsp_req.wdata; // R1 R23
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      host_res_data <= 32'h0000_0000;
    end else begin
      host_res_data <= result_word_r[host_res_sel]; // R1
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulse_out_level_0_r <= 16'h0000;
      pulse_out_level_1_r <= 16'h0000;
    end else if (dsp_wr_hit) begin
      if (dsp_req.addr == dor_pkg::ADDR_PULSE_0) begin
        pulse_out_level_0_r <= dsp_req.wdata[15:0]; // R3 R23
      end
      if (dsp_req.addr == dor_pkg::ADDR_PULSE_1) begin
        pulse_out_level_1_r <= dsp_req.wdata[15:0]; // R3 R23
      end
    end
  end
  assign pulse_out_level_0 = pulse_out_level_0_r;
  assign pulse_out_level_1 = pulse_out_level_1_r;

  // oscillator pin: two flops, then a third copy for the edge
  logic osc_meta_r;
  logic osc_sync_r;
  logic osc_prev_r;
  logic osc_tick;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_meta_r <= low_freq_osc_clock;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end
  assign osc_tick = osc_sync_r & ~osc_prev_r;

  logic [15:0] delay_timer_limit_r;
  logic [15:0] delay_count_r;
  logic        delay_run_r;
  logic        timer_wr;
  assign timer_wr = dsp_wr_hit && dsp_req.addr == dor_pkg::ADDR_TIMER;

  // a restart write outranks a tick in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      delay_timer_limit_r  <= 16'h0000;
      delay_count_r        <= 16'h0000;
      delay_run_r          <= 1'b0;
      delay_expired_flag_n <= 1'b1;
      wake_trigger         <= 1'b0;
    end else begin
      wake_trigger <= 1'b0;
      if (timer_wr) begin
        delay_timer_limit_r  <= dsp_req.wdata[15:0]; // R5
        delay_count_r        <= 16'h0000; // R5
        delay_run_r          <= 1'b1; // R4
        delay_expired_flag_n <= 1'b1;
      end else if (delay_run_r && osc_tick) begin
        if (delay_count_r == delay_timer_limit_r) begin
          wake_trigger         <= 1'b1; // R5
          delay_expired_flag_n <= 1'b0; // R7 R8
          delay_run_r          <= 1'b0; // R22
        end else begin
          delay_count_r <= delay_count_r + 16'h0001; // R4
        end
      end
    end
  end

  // nvram access registers
  logic [3:0]  mem_ctrl_r;
  logic [9:0]  mem_add_r;
  logic [31:0] mem_data_r;
  logic [31:0] mem_assy_r;
  logic [1:0]  mem_count_r;
  logic [7:0]  lock_byte;
  logic [2:0]  acc_lock;
  logic        acc_locked;
  logic        ctrl_wr;
  dor_pkg::dor_copy_t copy_r;
  logic [9:0]  copy_idx_r;

  assign lock_byte  = sram_r[dor_pkg::NV_LOCK_ADDR];
  assign acc_lock   = lock_index(mem_add_r);
  assign acc_locked = !acc_lock[2] && lock_byte[acc_lock[1:0]]; // R15
  assign ctrl_wr    = dsp_wr_hit && dsp_req.addr == dor_pkg::ADDR_MEM_CTRL;

  // store and recall bits act once per write; enable and protect persist
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_ctrl_r <= 4'h0;
      mem_add_r  <= 10'h000;
      mem_data_r <= 32'h0000_0000;
    end else begin
      if (ctrl_wr) begin
        mem_ctrl_r <= dsp_req.wdata[3:0]; // R10
      end
      if (dsp_wr_hit && dsp_req.addr == dor_pkg::ADDR_MEM_ADD) begin
        mem_add_r <= dsp_req.wdata[9:0]; // R11
      end else if (ctrl_wr && (dsp_req.wdata[dor_pkg::MEM_STORE_BIT] ||
                               dsp_req.wdata[dor_pkg::MEM_RECALL_BIT])) begin
        mem_add_r <= mem_add_r + 10'h001; // R9
      end
      if (dsp_wr_hit && dsp_req.addr == dor_pkg::ADDR_MEM_DATA) begin
        mem_data_r <= dsp_req.wdata; // R11
      end
    end
  end

  // a byte read shifts into the assembly word; locked bytes read as zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_assy_r  <= 32'h0000_0000;
      mem_count_r <= 2'h0;
    end else if (ctrl_wr && dsp_req.wdata[dor_pkg::MEM_RECALL_BIT]) begin
      mem_assy_r  <= {mem_assy_r[23:0],
                      acc_locked ? 8'h00 : sram_r[mem_add_r]}; // R9 R15
      mem_count_r <= mem_count_r + 2'h1;
    end else if (dsp_wr_hit && dsp_req.addr == dor_pkg::ADDR_MEM_ADD) begin
      mem_assy_r  <= 32'h0000_0000;
      mem_count_r <= 2'h0;
    end
  end

  logic sram_dsp_we;
  assign sram_dsp_we = ctrl_wr && dsp_req.wdata[dor_pkg::MEM_STORE_BIT] &&
                       mem_ctrl_r[dor_pkg::MEM_WE_BIT] &&
                       !mem_ctrl_r[dor_pkg::MEM_PROTECT_BIT] && !acc_locked; // R10 R15

  // sram: dsp byte writes, or whole-array recall from flash
  always_ff @(posedge core_clk) begin
    if (copy_r == dor_pkg::CP_RECALL || copy_r == dor_pkg::CP_BOOT) begin
      sram_r[copy_idx_r] <= flash_r[copy_idx_r]; // R16
    end else if (sram_dsp_we) begin
      sram_r[mem_add_r] <= mem_data_r[7:0]; // R11
    end
  end

  always_ff @(posedge core_clk) begin
    if (copy_r == dor_pkg::CP_STORE) begin
      flash_r[copy_idx_r] <= sram_r[copy_idx_r]; // R16
    end
  end

  // copy engine, one byte per cycle over the whole array
  logic boot_done_r;
  logic flash_valid_r;
  logic boot_seen_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      copy_r      <= dor_pkg::CP_IDLE;
      copy_idx_r  <= 10'h000;
      boot_done_r <= 1'b0;
      flash_busy  <= 1'b0;
    end else begin
      boot_done_r <= 1'b0;
      unique case (copy_r)
        dor_pkg::CP_IDLE: begin
          copy_idx_r <= 10'h000;
          if (flash_store_req) begin
            copy_r     <= dor_pkg::CP_STORE; // R16
            flash_busy <= 1'b1;
          end else if (flash_recall_req) begin
            copy_r     <= dor_pkg::CP_RECALL; // R16
            flash_busy <= 1'b1;
          end
        end
        dor_pkg::CP_STORE, dor_pkg::CP_RECALL, dor_pkg::CP_BOOT: begin
          copy_idx_r <= copy_idx_r + 10'h001;
          if (copy_idx_r == dor_pkg::NV_LAST) begin
            boot_done_r <= copy_r == dor_pkg::CP_BOOT;
            copy_r      <= dor_pkg::CP_IDLE;
            flash_busy  <= 1'b0;
          end
        end
        default: begin
          copy_r     <= dor_pkg::CP_IDLE;
          flash_busy <= 1'b0;
        end
      endcase
      // first cycle after reset release: pull stored contents in
      if (copy_r == dor_pkg::CP_IDLE && !flash_valid_r && flash_has_content &&
          !boot_seen_r) begin
        copy_r     <= dor_pkg::CP_BOOT; // R17 R18
        flash_busy <= 1'b1;
      end
    end
  end

  // content level from the flash macro is caught once after release
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      boot_seen_r   <= 1'b0;
      flash_valid_r <= 1'b0;
    end else begin
      boot_seen_r <= 1'b1;
      if (!boot_seen_r) begin
        flash_valid_r <= flash_has_content;
      end else if (copy_r == dor_pkg::CP_STORE) begin
        flash_valid_r <= 1'b1;
      end
    end
  end

  // boot mode decided from the recalled configuration byte
  logic [7:0] boot_byte;
  assign boot_byte = sram_r[dor_pkg::NV_BOOT_ADDR];
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      measure_start <= 1'b0;
      run_flag      <= 1'b0;
      device_idle   <= 1'b1;
    end else begin
      measure_start <= 1'b0;
      if (boot_done_r) begin
        run_flag      <= boot_byte[dor_pkg::BOOT_RUN_BIT];
        measure_start <= boot_byte[dor_pkg::BOOT_AUTO_BIT]; // R17
        device_idle   <= !boot_byte[dor_pkg::BOOT_AUTO_BIT]; // R18
      end
    end
  end

  // dsp read mux, answered one cycle after the request
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000; // R2
    unique case (dsp_req.addr)
      dor_pkg::ADDR_MEM_CTRL:  rd_mux = {28'h000_0000, mem_ctrl_r};
      dor_pkg::ADDR_MEM_ADD:   rd_mux = {22'h00_0000, mem_add_r};
      dor_pkg::ADDR_MEM_DATA:  rd_mux = mem_assy_r; // R11
      dor_pkg::ADDR_MEM_U8:    rd_mux = extend(mem_assy_r, 2'h1, 1'b0); // R9
      dor_pkg::ADDR_MEM_S8:    rd_mux = extend(mem_assy_r, 2'h1, 1'b1); // R9
      dor_pkg::ADDR_MEM_U16:   rd_mux = extend(mem_assy_r, 2'h2, 1'b0); // R9
      dor_pkg::ADDR_MEM_S16:   rd_mux = extend(mem_assy_r, 2'h2, 1'b1); // R9
      dor_pkg::ADDR_MEM_U24:   rd_mux = extend(mem_assy_r, 2'h3, 1'b0); // R9
      dor_pkg::ADDR_MEM_LAST:  rd_mux = extend(mem_assy_r, 2'h3, 1'b1); // R9
      dor_pkg::ADDR_TDC_START: rd_mux = tdc_info.tdc_start; // R20
      dor_pkg::ADDR_TDC_STOP:  rd_mux = tdc_info.tdc_stop; // R20
      dor_pkg::ADDR_CAP_PTR:   rd_mux = tdc_info.cap_result_pointer; // R20
      dor_pkg::ADDR_RES_PTR:   rd_mux = tdc_info.res_result_pointer; // R20
      default:                 rd_mux = 32'h0000_0000; // R2
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dsp_rdata <= 32'h0000_0000;
    end else if (dsp_req.rd) begin
      dsp_rdata <= rd_mux;
    end
  end

endmodule : dor_regs

`default_nettype wire

// ==== verification/dor_regs_props.sv ====
/*
  checker for the dsp special register bank, bound to dor_regs.
  assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dor_regs_props (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  // dsp side
  input wire dor_pkg::dor_dsp_req_t  dsp_req,
  input wire logic [31:0]            dsp_rdata,
  input wire logic                   delay_expired_flag_n,
  input wire logic                   wake_trigger,
  input wire dor_pkg::dor_tdc_info_t tdc_info,
  // outputs and flash
  input wire logic [15:0]            pulse_out_level_0,
  input wire logic [15:0]            pulse_out_level_1,
  input wire logic                   flash_store_req,
  input wire logic                   flash_busy,
  input wire logic                   measure_start,
  input wire logic                   device_idle
);
  logic [31:0] wdata_r;
  logic [31:0] start_r;
  logic        tmr_wr;

  // copies of inputs one cycle back, so the props need no struct $past
  always_ff @(posedge core_clk) wdata_r <= dsp_req.wdata;
  always_ff @(posedge core_clk) start_r <= tdc_info.tdc_start;
  assign tmr_wr = dsp_req.wr && dsp_req.addr == dor_pkg::ADDR_TIMER;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  wake_one_cycle_a: assert property (wake_trigger |=> !wake_trigger)
    else $error("wake trigger longer than one cycle");
  flag_on_wake_a: assert property (wake_trigger |-> !delay_expired_flag_n)
    else $error("expired flag not low with wake");
  flag_holds_a: assert property (!delay_expired_flag_n && !tmr_wr |=> !delay_expired_flag_n)
    else $error("expired flag left low state");
  timer_rearm_a: assert property (tmr_wr |=> delay_expired_flag_n && !wake_trigger)
    else $error("timer write did not rearm");
  result_hidden_a: assert property (dsp_req.rd && dsp_req.addr >= dor_pkg::ADDR_RES_FIRST
    && dsp_req.addr <= dor_pkg::ADDR_RES_LAST |=> dsp_rdata == 32'h0)
    else $error("result word readable by dsp");
  level_zero_a: assert property (dsp_req.wr && dsp_req.addr == dor_pkg::ADDR_PULSE_0
    |=> pulse_out_level_0 == wdata_r[15:0]) else $error("level 0 not written");
  level_one_a: assert property (dsp_req.wr && dsp_req.addr == dor_pkg::ADDR_PULSE_1
    |=> pulse_out_level_1 == wdata_r[15:0]) else $error("level 1 not written");
  tdc_read_a: assert property (dsp_req.rd && dsp_req.addr == dor_pkg::ADDR_TDC_START
    |=> dsp_rdata == start_r) else $error("conversion start read wrong");
  store_busy_a: assert property (flash_store_req && !flash_busy |=> flash_busy[*8])
    else $error("store did not raise busy");
  boot_run_a: assert property (measure_start |=> !measure_start && !device_idle)
    else $error("autoboot left device idle");

  wake_c: cover property (wake_trigger);
  store_c: cover property ($rose(flash_busy));
  boot_c: cover property (measure_start);
endmodule : dor_regs_props

bind dor_regs dor_regs_props u_props (
  .core_clk(core_clk), .rst_b(rst_b), .dsp_req(dsp_req), .dsp_rdata(dsp_rdata),
  .delay_expired_flag_n(delay_expired_flag_n), .wake_trigger(wake_trigger),
  .tdc_info(tdc_info), .pulse_out_level_0(pulse_out_level_0),
  .pulse_out_level_1(pulse_out_level_1), .flash_store_req(flash_store_req),
  .flash_busy(flash_busy), .measure_start(measure_start), .device_idle(device_idle));

`default_nettype wire

// ==== verification/dor_osc_model.sv ====
/*
  free-running low-frequency oscillator feeding the delay timer.
  assumes nothing; period 1700 ns, phase unrelated to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module dor_osc_model (
  // oscillator pin
  output var logic osc_clk
);
  // runs free: the oscillator never stops between timer uses
  initial begin
    osc_clk = 1'b0;
    #37;
    forever #850 osc_clk = ~osc_clk;
  end
endmodule : dor_osc_model

`default_nettype wire

// ==== verification/test_dor_regs.sv ====
/*
  testbench for dor_regs: dsp register tasks, host reads, timer, nvram, boot.
  assumes dor_osc_model drives the oscillator pin.
*/
`timescale 1ns/1ps
`default_nettype none

module test_dor_regs;
  logic core_clk, rst_b, delay_expired_flag_n, wake_trigger, low_freq_osc_clock;
  logic flash_store_req, flash_recall_req, flash_has_content, flash_busy;
  logic measure_start, run_flag, device_idle;
  logic [31:0] dsp_rdata, host_res_data, v;
  logic [15:0] pulse_out_level_0, pulse_out_level_1;
  logic [2:0] host_res_sel;
  dor_pkg::dor_dsp_req_t dsp_req;
  dor_pkg::dor_tdc_info_t tdc_info;
  int miscompares, samples_checked, cyc, n, wakes;

  dor_regs uut (.core_clk(core_clk), .rst_b(rst_b), .dsp_req(dsp_req),
    .dsp_rdata(dsp_rdata), .delay_expired_flag_n(delay_expired_flag_n),
    .wake_trigger(wake_trigger), .tdc_info(tdc_info), .host_res_sel(host_res_sel),
    .host_res_data(host_res_data), .pulse_out_level_0(pulse_out_level_0),
    .pulse_out_level_1(pulse_out_level_1), .low_freq_osc_clock(low_freq_osc_clock),
    .flash_store_req(flash_store_req), .flash_recall_req(flash_recall_req),
    .flash_has_content(flash_has_content), .flash_busy(flash_busy),
    .measure_start(measure_start), .run_flag(run_flag), .device_idle(device_idle));
  dor_osc_model osc (.osc_clk(low_freq_osc_clock));

  always #50 core_clk = ~core_clk;

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge core_clk) begin
    cyc++;
    if (wake_trigger === 1'b1) wakes++;
    if (cyc == 8000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic dsp_wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge core_clk);
    dsp_req.wr <= 1'b1;
    dsp_req.addr <= a;
    dsp_req.wdata <= d;
    @(posedge core_clk);
    dsp_req.wr <= 1'b0;
  endtask : dsp_wr

  // sampled two edges after the request so the registered answer has landed
  task automatic dsp_rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge core_clk);
    dsp_req.rd <= 1'b1;
    dsp_req.addr <= a;
    @(posedge core_clk);
    dsp_req.rd <= 1'b0;
    @(posedge core_clk);
    #1 d = dsp_rdata;
  endtask : dsp_rd

  task automatic nv_wr(input logic [9:0] a, input logic [7:0] d);
    dsp_wr(dor_pkg::ADDR_MEM_ADD, {22'h0, a});
    dsp_wr(dor_pkg::ADDR_MEM_DATA, {24'h0, d});
    // the store strobe checks the enable left by the previous control write
    dsp_wr(dor_pkg::ADDR_MEM_CTRL, 32'h4);
    dsp_wr(dor_pkg::ADDR_MEM_CTRL, 32'h5);
  endtask : nv_wr

  task automatic nv_rd(input logic [9:0] a, input int nb, input logic [6:0] f,
                       output logic [31:0] d);
    dsp_wr(dor_pkg::ADDR_MEM_ADD, {22'h0, a});
    repeat (nb) dsp_wr(dor_pkg::ADDR_MEM_CTRL, 32'h2);
    dsp_rd(f, d);
  endtask : nv_rd

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    dsp_req = '0;
    host_res_sel = 3'h0;
    flash_store_req = 1'b0;
    flash_recall_req = 1'b0;
    flash_has_content = 1'b0;
    tdc_info = {32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'h4444_0004};
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1 chk({delay_expired_flag_n, wake_trigger, device_idle, flash_busy}, 32'hA);
    for (int i = 0; i < 8; i++) dsp_wr(dor_pkg::ADDR_RES_FIRST + 7'(i), 32'hC0DE_0000 + 32'(i) * 32'h101);
    for (int i = 0; i < 8; i++) begin
      host_res_sel <= 3'(i);
      repeat (2) @(posedge core_clk);
      #1 chk(host_res_data, 32'hC0DE_0000 + 32'(i) * 32'h101);
    end
    dsp_rd(dor_pkg::ADDR_RES_FIRST + 7'h3, v);
    chk(v, 32'h0);
    dsp_wr(dor_pkg::ADDR_PULSE_0, 32'h0000_8001);
    dsp_wr(dor_pkg::ADDR_PULSE_1, 32'h0000_7FFE);
    #1 chk({pulse_out_level_0, pulse_out_level_1}, 32'h8001_7FFE);
    for (int i = 0; i < 4; i++) begin
      dsp_rd(dor_pkg::ADDR_TDC_START + 7'(i), v);
      chk(v, tdc_info[127 - 32 * i -: 32]);
    end
    // limit 3 fires on the fourth oscillator tick, 17 core cycles apart
    wakes = 0;
    dsp_wr(dor_pkg::ADDR_TIMER, 32'h3);
    n = 0;
    while (wakes == 0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n >= 48 && n <= 76), 32'h1);
    repeat (150) @(posedge core_clk);
    #1 chk(32'(wakes), 32'h1);
    chk(32'(delay_expired_flag_n), 32'h0);
    dsp_wr(dor_pkg::ADDR_TIMER, 32'hFFFF);
    #1 chk(32'(delay_expired_flag_n), 32'h1);
    // sram powers up unknown: clear the lock byte before any guarded access
    nv_wr(dor_pkg::NV_LOCK_ADDR, 8'h00);
    nv_wr(10'h005, 8'hA5);
    nv_wr(10'h006, 8'h81);
    nv_rd(10'h005, 1, 7'h73, v);
    chk(v, 32'h0000_00A5);
    nv_rd(10'h005, 1, 7'h74, v);
    chk(v, 32'hFFFF_FFA5);
    nv_rd(10'h005, 2, 7'h75, v);
    chk(v, 32'h0000_A581);
    nv_rd(10'h005, 2, 7'h76, v);
    chk(v, 32'hFFFF_A581);
    dsp_wr(dor_pkg::ADDR_MEM_ADD, 32'h5);
    dsp_wr(dor_pkg::ADDR_MEM_DATA, 32'h3C);
    dsp_wr(dor_pkg::ADDR_MEM_CTRL, 32'hC);
    dsp_wr(dor_pkg::ADDR_MEM_CTRL, 32'hD);
    nv_rd(10'h005, 1, 7'h73, v);
    chk(v, 32'h0000_00A5);
    nv_wr(dor_pkg::NV_BOOT_ADDR, 8'h01);
    nv_wr(dor_pkg::NV_LOCK_ADDR, 8'h01);
    nv_wr(10'h005, 8'h11);
    nv_rd(10'h005, 1, 7'h73, v);
    chk(v, 32'h0);
    nv_wr(10'h2C0, 8'h5A);
    nv_rd(10'h2C0, 1, 7'h73, v);
    chk(v, 32'h0000_005A);
    @(posedge core_clk);
    flash_store_req <= 1'b1;
    @(posedge core_clk);
    flash_store_req <= 1'b0;
    #1 n = 0;
    while (flash_busy === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(32'(n), 32'd1024);
    // second reset with stored contents and autoboot set in the boot byte
    @(posedge core_clk);
    flash_has_content <= 1'b1;
    rst_b <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    n = 0;
    while (measure_start !== 1'b1 && n < 1200) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(32'(measure_start), 32'h1);
    @(posedge core_clk);
    #1 chk({device_idle, run_flag}, 32'h0);
    nv_rd(10'h2C0, 1, 7'h73, v);
    chk(v, 32'h0000_005A);
    tally_and_finish();
  end
endmodule : test_dor_regs

`default_nettype wire
